/* pkg/csgf_pkg.sv */
package csgf_pkg;
  // register location on the serial configuration bus
  localparam logic [6:0] CSGF_CFG_ADDR     = 7'h11;
  // field layout of receiver_gain_sense_config
  localparam int         CSGF_ASSERT_LSB   = 6;   // assert-count, 2 bits
  localparam int         CSGF_DEASSERT_BIT = 5;   // deassert-count, 1 bit
  localparam int         CSGF_HOLD_LSB     = 2;   // hold code, 3 bits
  localparam int         CSGF_EXTRA_LSB    = 0;   // extra-hold code, 2 bits
  localparam logic [7:0] CSGF_CFG_RESET    = 8'h65;
  // hold code that freezes levels for as long as it is selected
  localparam logic [2:0] CSGF_HOLD_FOREVER = 3'h7;
  // hold lengths in filter clocks, codes 0 to 6
  localparam logic [5:0] CSGF_HOLD_C0      = 6'h10;
  localparam logic [5:0] CSGF_HOLD_C1      = 6'h14;
  localparam logic [5:0] CSGF_HOLD_C2      = 6'h18;
  localparam logic [5:0] CSGF_HOLD_C3      = 6'h1c;
  localparam logic [5:0] CSGF_HOLD_C4      = 6'h20;
  localparam logic [5:0] CSGF_HOLD_C5      = 6'h28;
  localparam logic [5:0] CSGF_HOLD_C6      = 6'h30;
  // extra hold lengths in converter sample clocks, codes 0 to 3
  localparam logic [7:0] CSGF_EXTRA_C0     = 8'h10;
  localparam logic [7:0] CSGF_EXTRA_C1     = 8'h20;
  localparam logic [7:0] CSGF_EXTRA_C2     = 8'h40;
  localparam logic [7:0] CSGF_EXTRA_C3     = 8'h80;

  typedef enum logic [1:0] {
    CSGF_IDLE,
    CSGF_ARMED,
    CSGF_HOLD,
    CSGF_EXTRA
  } csgf_state_type;
endpackage : csgf_pkg

/* src/csgf_top.sv */
// Notes on behaviour
// - carrier sense rises only after a run of assert-count plus one samples at or above the level.
// - a set carrier sense falls after one sample below the level, or two when the deassert-count bit is set.
// - the qualified carrier sense is also driven on the lock pin for the host to watch.
// - after a gain change that follows one of the events below, levels freeze for 16 to 48 filter clocks by code; code 7 freezes them while it is selected.
// - a gain change after a channel switch, lock loss or power-up freezes gain, sync, frequency and strength.
// - the same events add a further freeze of 16, 32, 64 or 128 converter sample clocks.
`timescale 1ns/10ps
`default_nettype none
module csgf_top
  import csgf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       cfg_wr_in,
  input  wire logic [6:0] cfg_addr_in,
  input  wire logic [7:0] cfg_wdata_in,
  input  wire logic       sample_valid_in,
  input  wire logic       above_level_in,
  input  wire logic       filter_tick_in,
  input  wire logic       adc_tick_in,
  input  wire logic       gain_change_in,
  input  wire logic       chan_switch_in,
  input  wire logic       lock_loss_in,
  input  wire logic       rx_powerup_in,
  output logic [7:0]      cfg_rdata_out,
  output logic            carrier_sense_out,
  output logic            lock_pin_out,
  output logic            freeze_out
);

  logic [7:0]     cfg;
  logic [1:0]     above_run;
  logic           below_run;
  logic           cs;
  csgf_state_type state;
  logic [7:0]     count;
  logic [7:0]     next_count;
  logic           next_freeze;

  wire logic [1:0] assert_cnt = cfg[CSGF_ASSERT_LSB +: 2];
  wire logic       deassert2  = cfg[CSGF_DEASSERT_BIT];
  wire logic [2:0] hold_code  = cfg[CSGF_HOLD_LSB +: 3];
  wire logic [1:0] extra_code = cfg[CSGF_EXTRA_LSB +: 2];
  wire logic       trigger    = chan_switch_in | lock_loss_in | rx_powerup_in;

  function automatic logic [7:0] hold_len(input logic [2:0] code);
    case (code)
      3'h0:    hold_len = {2'h0, CSGF_HOLD_C0};
      3'h1:    hold_len = {2'h0, CSGF_HOLD_C1};
      3'h2:    hold_len = {2'h0, CSGF_HOLD_C2};
      3'h3:    hold_len = {2'h0, CSGF_HOLD_C3};
      3'h4:    hold_len = {2'h0, CSGF_HOLD_C4};
      3'h5:    hold_len = {2'h0, CSGF_HOLD_C5};
      default: hold_len = {2'h0, CSGF_HOLD_C6};
    endcase
  endfunction : hold_len

  function automatic logic [7:0] extra_len(input logic [1:0] code);
    case (code)
      2'h0:    extra_len = CSGF_EXTRA_C0;
      2'h1:    extra_len = CSGF_EXTRA_C1;
      2'h2:    extra_len = CSGF_EXTRA_C2;
      default: extra_len = CSGF_EXTRA_C3;
    endcase
  endfunction : extra_len

  // configuration register, write and read back
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg           <= CSGF_CFG_RESET;
      cfg_rdata_out <= CSGF_CFG_RESET;
    end else begin
      if (cfg_wr_in && cfg_addr_in == CSGF_CFG_ADDR) begin
        cfg <= cfg_wdata_in;
      end
      cfg_rdata_out <= cfg;
    end
  end

  // run counters; a sample of the other kind restarts the run
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      above_run <= 2'h0;
      below_run <= 1'b0;
    end else if (sample_valid_in) begin
      if (above_level_in) begin
        below_run <= 1'b0;
        if (above_run != 2'h3) begin
          above_run <= above_run + 2'h1;
        end
      end else begin
        above_run <= 2'h0;
        below_run <= 1'b1;
      end
    end
  end

  // qualified carrier sense; above_run counts the samples before this one
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs <= 1'b0;
    end else if (sample_valid_in) begin
      if (above_level_in && !cs && above_run >= assert_cnt) begin
        cs <= 1'b1;
      end else if (!above_level_in && cs && (!deassert2 || below_run)) begin
        cs <= 1'b0;
      end
    end
  end

  // outputs registered so the pin sees no glitch
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      carrier_sense_out <= 1'b0;
      lock_pin_out      <= 1'b0;
    end else begin
      carrier_sense_out <= cs;
      lock_pin_out      <= cs;
    end
  end

  // freeze sequencer: armed by an event, started by the next gain change
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= CSGF_IDLE;
      count <= 8'h0;
    end else begin
      count <= next_count;
      case (state)
        CSGF_IDLE: begin
          if (trigger) begin
            state <= CSGF_ARMED;
          end
        end
        CSGF_ARMED: begin
          if (gain_change_in) begin
            state <= CSGF_HOLD;
          end
        end
        CSGF_HOLD: begin
          if (filter_tick_in && count == 8'h1 && hold_code != CSGF_HOLD_FOREVER) begin
            state <= CSGF_EXTRA;
          end
        end
        CSGF_EXTRA: begin
          if (adc_tick_in && count == 8'h1) begin
            state <= trigger ? CSGF_ARMED : CSGF_IDLE;
          end
        end
        default: state <= CSGF_IDLE;
      endcase
    end
  end

  // counter loads on each phase entry, counts its own clock down
  always_comb begin
    next_count = count;
    case (state)
      CSGF_ARMED: begin
        next_count = hold_len(hold_code);
      end
      CSGF_HOLD: begin
        if (filter_tick_in && count == 8'h1) begin
          next_count = extra_len(extra_code);
        end else if (filter_tick_in && count != 8'h0) begin
          next_count = count - 8'h1;
        end
      end
      CSGF_EXTRA: begin
        if (adc_tick_in && count != 8'h0) begin
          next_count = count - 8'h1;
        end
      end
      default: next_count = 8'h0;
    endcase
  end

  // code 7 freezes whatever the sequencer does
  always_comb begin
    next_freeze = (hold_code == CSGF_HOLD_FOREVER) ||
                  (state == CSGF_HOLD) || (state == CSGF_EXTRA) ||
                  (state == CSGF_ARMED && gain_change_in);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      freeze_out <= 1'b0;
    end else begin
      freeze_out <= next_freeze;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  chk_cs_assert_run: assert property (
    $rose(cs) |-> $past(sample_valid_in) && $past(above_level_in) && $past(above_run) >= $past(assert_cnt))
    else $error("carrier sense rose without a full run");
  chk_cs_deassert_run: assert property (
    $fell(cs) |-> $past(sample_valid_in) && !$past(above_level_in) && (!$past(deassert2) || $past(below_run)))
    else $error("carrier sense fell too early");
  chk_lock_pin_mirror: assert property (
    ##1 lock_pin_out == $past(cs))
    else $error("lock pin does not follow carrier sense");
  chk_hold_forever: assert property (
    hold_code == CSGF_HOLD_FOREVER |=> freeze_out)
    else $error("code 7 did not freeze");
  chk_freeze_start: assert property (
    state == CSGF_ARMED && gain_change_in |=> state == CSGF_HOLD ##0 freeze_out)
    else $error("gain change did not start freeze");
  chk_extra_follows: assert property (
    state == CSGF_HOLD && filter_tick_in && count == 8'h1 && hold_code != CSGF_HOLD_FOREVER
      |=> state == CSGF_EXTRA && count == extra_len($past(extra_code)))
    else $error("extra hold not loaded");
  chk_run_restart: assert property (
    sample_valid_in && !above_level_in |=> above_run == 2'h0)
    else $error("run counter not restarted");
  chk_hold_load: assert property (
    state == CSGF_ARMED && gain_change_in |=> count == hold_len($past(hold_code)))
    else $error("hold length not loaded");

endmodule : csgf_top
`default_nettype wire

/* verif/csgf_host.sv */
`timescale 1ns/10ps
`default_nettype none
// host side: samples the lock pin as a plain input, no register reads
module csgf_host (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic lock_pin_in,
  output logic      lock_seen_out
);
  // one flop stands in for the host's pin synchroniser
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) lock_seen_out <= 1'b0;
    else lock_seen_out <= lock_pin_in;
  end
endmodule : csgf_host
`default_nettype wire

/* verif/tb_carrier_sense_and_gain_freeze.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_carrier_sense_and_gain_freeze;
  import csgf_pkg::*;
  logic       clk, arst_n, wr, sv, above, cs, lk, fz, seen;
  logic       ft, at; // filter and converter tick strobes
  logic [6:0] addr;
  logic [7:0] wd, rd;
  logic [3:0] ev; // gain, channel switch, lock loss, power-up
  int         fails, compares, n;
  csgf_top i_dut (.clk_in(clk), .arst_n_in(arst_n), .cfg_wr_in(wr), .cfg_addr_in(addr),
    .cfg_wdata_in(wd), .sample_valid_in(sv), .above_level_in(above), .filter_tick_in(ft),
    .adc_tick_in(at), .gain_change_in(ev[0]), .chan_switch_in(ev[1]), .lock_loss_in(ev[2]),
    .rx_powerup_in(ev[3]), .cfg_rdata_out(rd), .carrier_sense_out(cs), .lock_pin_out(lk),
    .freeze_out(fz));
  csgf_host i_host (.clk_in(clk), .arst_n_in(arst_n), .lock_pin_in(lk), .lock_seen_out(seen));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task do_reset;
    arst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
  endtask : do_reset
  // write then wait for the copy to reach the read port
  task cfg_write(input logic [6:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1 wr = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : cfg_write
  // a run of k like samples, three idle cycles after so calls never collide
  task samples(input int k, input logic a);
    sv = 1'b1;
    above = a;
    repeat (k) @(posedge clk);
    #1 sv = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : samples
  task cs_is(input logic e);
    chk({7'h0, cs}, {7'h0, e});
    chk({7'h0, lk}, {7'h0, e});
    chk({7'h0, seen}, {7'h0, e});
  endtask : cs_is
  // optional arming pulse, then a gain pulse on the next cycle
  task events(input logic [3:0] arm);
    if (arm != 4'h0) begin
      ev = arm;
      @(posedge clk);
      #1;
    end
    ev = 4'h1;
    @(posedge clk);
    #1 ev = 4'h0;
  endtask : events
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial begin
    logic [5:0] hold [7];
    hold = '{6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h28, 6'h30};
    fails = 0;
    compares = 0;
    {wr, sv, above, addr, wd, ev} = '0;
    {ft, at} = 2'b11;
    do_reset();
    chk(rd, 8'h65);
    cfg_write(7'h11, 8'h9a);
    chk(rd, 8'h9a);
    cfg_write(7'h12, 8'h00);
    chk(rd, 8'h9a); // other addresses leave the register alone
    $display("test register done");
    for (int k = 0; k < 4; k++) begin
      cfg_write(7'h11, {k[1:0], k[0], 5'h00});
      samples(k, 1'b1);
      samples(1, 1'b0);
      samples(k, 1'b1);
      cs_is(1'b0);
      samples(1, 1'b1);
      cs_is(1'b1);
      samples(1, 1'b0);
      if (k[0]) begin
        cs_is(1'b1);
        samples(1, 1'b1);
        samples(1, 1'b0);
        cs_is(1'b1);
        samples(1, 1'b0);
      end
      cs_is(1'b0);
    end
    $display("test carrier sense done");
    for (int h = 0; h < 7; h++) begin
      cfg_write(7'h11, {3'h0, h[2:0], h[1:0]});
      events(4'h0);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, fz}, 8'h00);
      events(4'h2 << (h % 3));
      n = 0;
      for (int c = 0; c < 400 && (fz === 1'b1 || n == 0); c++) begin
        @(posedge clk);
        #1 if (fz === 1'b1) n++;
      end
      chk(n[7:0], 8'({2'h0, hold[h]}) + (8'h10 << h[1:0]));
    end
    $display("test freeze lengths done");
    // hold phase must wait for filter ticks, extra phase for converter ticks
    cfg_write(7'h11, 8'h00);
    {ft, at} = 2'b01;
    events(4'h2);
    repeat (40) @(posedge clk);
    #1 chk({7'h0, fz}, 8'h01);
    {ft, at} = 2'b10;
    repeat (40) @(posedge clk);
    #1 chk({7'h0, fz}, 8'h01);
    at = 1'b1;
    repeat (24) @(posedge clk);
    #1 chk({7'h0, fz}, 8'h00);
    $display("test tick gating done");
    cfg_write(7'h11, 8'h1c);
    chk({7'h0, fz}, 8'h01);
    repeat (60) @(posedge clk);
    #1 chk({7'h0, fz}, 8'h01);
    do_reset();
    chk({7'h0, fz}, 8'h00);
    chk(rd, 8'h65);
    $display("test endless freeze done");
    report_and_stop();
  end
endmodule : tb_carrier_sense_and_gain_freeze
`default_nettype wire
